/* File: include/sep_consts.svh */
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

// control register
`define SEP_CTRL_ADDR 8'h40
`define SEP_BIT_SELECT 4
`define SEP_BIT_SHIFTCLK 5
`define SEP_BIT_SERIN 6
`define SEP_BIT_SEROUT 7
`define SEP_CTRL_RESET 8'h00
`define SEP_UNUSED_MASK 8'h0F

// instruction layout
`define SEP_INSTR_BITS 12
`define SEP_DATA_BITS 8
`define SEP_OP_READ 2'b10
`define SEP_OP_ERASE 2'b11
`define SEP_OP_WRITE 2'b01
`define SEP_OP_SPECIAL 2'b00
`define SEP_SUB_ENABLE 2'b11
`define SEP_SUB_DISABLE 2'b00
`define SEP_SUB_ERASEALL 2'b10
`define SEP_SUB_WRITEALL 2'b01
`define SEP_ERASED_WORD 8'hFF

// internal program cycle time
`define SEP_PROG_TIME_US 2
`define SEP_CLK_MHZ 100
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_US * `SEP_CLK_MHZ)

`endif

/* File: include/sep_pkg.sv */
package sep_pkg;
   typedef enum logic [5:0] {
      SEP_IDLE = 6'b00_0001,
      SEP_CMD = 6'b00_0010,
      SEP_DATA = 6'b00_0100,
      SEP_READ = 6'b00_1000,
      SEP_WAITCS = 6'b01_0000,
      SEP_BUSY = 6'b10_0000
   } sep_state_type;
endpackage

/* File: hw/sep_mem.sv */
`timescale 1ns/1ns
module sep_mem #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 8,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] cells [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
      rdata <= cells[raddr];
   end
endmodule // sep_mem

/* File: hw/sep_buf.sv */
`timescale 1ns/1ns
module sep_buf #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   // ------------------------------
   // two-entry skid buffer
   // ------------------------------
   logic [WIDTH-1:0] slot [2];
   logic [1:0] count;
   logic rdPtr;
   logic wrPtr;
   logic doPush;
   logic doPop;

   assign inReady = (count != 2'd2);
   assign outValid = (count != 2'd0);
   assign outData = slot[rdPtr];
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 2'd0;
         rdPtr <= 1'b0;
         wrPtr <= 1'b0;
      end else begin
         if (doPush) begin
            wrPtr <= ~wrPtr;
         end
         if (doPop) begin
            rdPtr <= ~rdPtr;
         end
         if (doPush && !doPop) begin
            count <= count + 2'd1;
         end else if (doPop && !doPush) begin
            count <= count - 2'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (doPush) begin
         slot[wrPtr] <= inData;
      end
   end
endmodule // sep_buf

/* File: hw/serial_data_eeprom_port.sv */
`timescale 1ns/1ns
`include "sep_consts.svh"
// Notes on behaviour
// - low four control bits read zero
// - bits 4..7: select, clock, in, out
// - array holds 256 eight-bit words
// - instruction: start, two opcode, nine address
// - serial in sampled on clock rise
// - output high whenever select is low
// - powers up write-disabled; programs need enable
// - read: zero dummy then eight bits
// - reads work whether enabled or not
// - read address increments, wraps, streams on
// - enable holds until disable or reset
// - erase starts on select fall, self-timed
// - output low while busy, high when done
// - write starts on select fall, stores word in one step
// - erase-all sets every cell to ones
// - write-all copies data to every word
// - opcodes: read 10, erase 11, write 01
// - opcode 00 subcodes: enable/disable/eraseall/writeall
module serial_data_eeprom_port
   import sep_pkg::*;
#(
   parameter int WORDS = 256,
   parameter int PROG_CYCLES = `SEP_PROG_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic progBusy
);
   // ------------------------------
   // control register bits
   // ------------------------------
   logic chipSelect;
   logic eeprom_shift_clock;
   logic eeprom_serial_in;
   logic serialOut;
   logic ctrlHit;

   assign ctrlHit = (regAddr == `SEP_CTRL_ADDR);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chipSelect <= 1'b0;
         eeprom_shift_clock <= 1'b0;
         eeprom_serial_in <= 1'b0;
      end else if (regWrite && ctrlHit) begin
         chipSelect <= regWdata[`SEP_BIT_SELECT];
         eeprom_shift_clock <= regWdata[`SEP_BIT_SHIFTCLK];
         eeprom_serial_in <= regWdata[`SEP_BIT_SERIN];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdata <= `SEP_CTRL_RESET;
      end else if (regRead && ctrlHit) begin
         regRdata <= {serialOut, eeprom_serial_in, eeprom_shift_clock,
                      chipSelect, 4'h0};
      end
   end

   // ------------------------------
   // edge detection
   // ------------------------------
   logic clkPrev;
   logic selPrev;
   logic clkRise;
   logic selFall;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clkPrev <= 1'b0;
         selPrev <= 1'b0;
      end else begin
         clkPrev <= eeprom_shift_clock;
         selPrev <= chipSelect;
      end
   end

   assign clkRise = eeprom_shift_clock && !clkPrev && chipSelect;
   assign selFall = selPrev && !chipSelect;

   // ------------------------------
   // storage array
   // ------------------------------
   logic memWe;
   logic [7:0] memWaddr;
   logic [7:0] memWdata;
   logic [7:0] memRaddr;
   logic [7:0] memRdata;

   sep_mem #(.DEPTH(WORDS), .WIDTH(`SEP_DATA_BITS), .AW(8)) u_mem (
      .clk(clk),
      .we(memWe),
      .waddr(memWaddr),
      .wdata(memWdata),
      .raddr(memRaddr),
      .rdata(memRdata)
   );

   // ------------------------------
   // read word buffer
   // ------------------------------
   logic bufInValid;
   logic bufInReady;
   logic bufOutValid;
   logic bufOutReady;
   logic [7:0] bufOutData;
   logic fetchPending;

   sep_buf #(.WIDTH(`SEP_DATA_BITS)) u_buf (
      .clk(clk),
      .rst(rst),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(memRdata),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOutData)
   );

   // ------------------------------
   // instruction engine
   // ------------------------------
   sep_state_type state;
   logic [11:0] shiftIn;
   logic [3:0] bitCount;
   logic [7:0] addr;
   logic [1:0] opcode;
   logic [7:0] dataIn;
   logic [7:0] readShift;
   logic [3:0] readCount;
   logic programEnabled;
   logic [1:0] pendingOp;
   logic [15:0] progTimer;
   logic [8:0] sweep;
   logic allMode;
   logic [7:0] progData;
   logic [11:0] nextShift;

   assign nextShift = {shiftIn[10:0], eeprom_serial_in};
   // pop on each word boundary; drain stale words outside a read
   assign bufOutReady = (state == SEP_READ)
                        ? (clkRise && (readCount == 4'd0 ||
                                       readCount == 4'(`SEP_DATA_BITS)))
                        : 1'b1;

   // read prefetch: request word at current address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetchPending <= 1'b0;
         bufInValid <= 1'b0;
      end else begin
         bufInValid <= fetchPending && bufInReady;
         fetchPending <= 1'b0;
         if (state == SEP_READ && !bufOutValid && !bufInValid
             && !fetchPending) begin
            fetchPending <= 1'b1;
         end
      end
   end
   assign memRaddr = addr;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= SEP_IDLE;
         shiftIn <= 12'h000;
         bitCount <= 4'd0;
         addr <= 8'h00;
         opcode <= 2'b00;
         dataIn <= 8'h00;
         readShift <= 8'h00;
         readCount <= 4'd0;
         programEnabled <= 1'b0;
         pendingOp <= 2'b00;
         progTimer <= 16'h0000;
         sweep <= 9'h000;
         allMode <= 1'b0;
         progData <= 8'h00;
         serialOut <= 1'b1;
         memWe <= 1'b0;
         memWaddr <= 8'h00;
         memWdata <= 8'h00;
      end else begin
         memWe <= 1'b0;
         case (state)
            SEP_IDLE: begin
               bitCount <= 4'd0;
               // sample on rise, wait start bit
               if (clkRise && eeprom_serial_in) begin
                  shiftIn <= 12'h001;
                  bitCount <= 4'd1;
                  state <= SEP_CMD;
               end
            end
            SEP_CMD: begin
               if (!chipSelect) begin
                  state <= SEP_IDLE;
               end else if (clkRise) begin
                  shiftIn <= nextShift;
                  bitCount <= bitCount + 4'd1;
                  if (bitCount == 4'(`SEP_INSTR_BITS - 1)) begin
                     opcode <= nextShift[10:9];
                     addr <= nextShift[7:0];
                     bitCount <= 4'd0;
                     if (nextShift[10:9] == `SEP_OP_READ) begin
                        readCount <= 4'd0;
                        state <= SEP_READ;
                     end else if (nextShift[10:9] == `SEP_OP_WRITE ||
                                  (nextShift[10:9] == `SEP_OP_SPECIAL &&
                                   nextShift[8:7] == `SEP_SUB_WRITEALL)) begin
                        state <= SEP_DATA;
                     end else begin
                        if (nextShift[10:9] == `SEP_OP_SPECIAL) begin
                           if (nextShift[8:7] == `SEP_SUB_ENABLE) begin
                              programEnabled <= 1'b1;
                           end else if (nextShift[8:7] ==
                                        `SEP_SUB_DISABLE) begin
                              programEnabled <= 1'b0;
                           end
                        end
                        state <= SEP_WAITCS;
                     end
                  end
               end
            end
            SEP_DATA: begin
               if (!chipSelect) begin
                  state <= SEP_IDLE;
               end else if (clkRise) begin
                  dataIn <= {dataIn[6:0], eeprom_serial_in};
                  bitCount <= bitCount + 4'd1;
                  if (bitCount == 4'(`SEP_DATA_BITS - 1)) begin
                     state <= SEP_WAITCS;
                  end
               end
            end
            SEP_READ: begin
               if (!chipSelect) begin
                  state <= SEP_IDLE;
               end else if (clkRise) begin
                  if (readCount == 4'd0) begin
                     // zero dummy bit, first word only
                     serialOut <= 1'b0;
                     readShift <= bufOutData;
                     readCount <= 4'd1;
                     addr <= addr + 8'd1;
                  end else if (readCount == 4'(`SEP_DATA_BITS)) begin
                     // last bit out, next word follows
                     serialOut <= readShift[7];
                     readShift <= bufOutData;
                     readCount <= 4'd1;
                     addr <= addr + 8'd1;
                  end else begin
                     serialOut <= readShift[7];
                     readShift <= {readShift[6:0], 1'b0};
                     readCount <= readCount + 4'd1;
                  end
               end
            end
            SEP_WAITCS: begin
               if (selFall) begin
                  state <= SEP_IDLE;
                  if (programEnabled && opcode != `SEP_OP_READ &&
                      !(opcode == `SEP_OP_SPECIAL &&
                        (shiftIn[8:7] == `SEP_SUB_ENABLE ||
                         shiftIn[8:7] == `SEP_SUB_DISABLE))) begin
                     progTimer <= 16'(PROG_CYCLES);
                     allMode <= (opcode == `SEP_OP_SPECIAL);
                     progData <= (opcode == `SEP_OP_WRITE ||
                                  opcode == `SEP_OP_SPECIAL &&
                                  shiftIn[8:7] == `SEP_SUB_WRITEALL)
                                 ? dataIn : `SEP_ERASED_WORD;
                     sweep <= 9'h000;
                     state <= SEP_BUSY;
                  end
               end
            end
            SEP_BUSY: begin
               if (progTimer != 16'h0000) begin
                  progTimer <= progTimer - 16'h0001;
               end else if (!allMode) begin
                  memWe <= 1'b1;
                  memWaddr <= addr;
                  memWdata <= progData;
                  state <= SEP_IDLE;
               end else begin
                  memWe <= 1'b1;
                  memWaddr <= sweep[7:0];
                  memWdata <= progData;
                  sweep <= sweep + 9'd1;
                  if (sweep == 9'(WORDS - 1)) begin
                     state <= SEP_IDLE;
                  end
               end
            end
            default: state <= SEP_IDLE;
         endcase
         if (!chipSelect) begin
            serialOut <= 1'b1;
         end else if (state == SEP_BUSY) begin
            serialOut <= 1'b0;
         end else if (state != SEP_READ) begin
            serialOut <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         progBusy <= 1'b0;
      end else begin
         progBusy <= (state == SEP_BUSY);
      end
   end
endmodule // serial_data_eeprom_port

/* File: tb/sep_port_properties.sv */
`timescale 1ns/1ns
module sep_port_properties #(
   parameter int WORDS = 256,
   parameter int PROG_CYCLES = 200
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic progBusy
);
   logic [7:0] shadow;
   logic [3:0] sinceFall;
   logic [9:0] busyLen;
   logic ctrlWr;
   assign ctrlWr = regWrite && regAddr == 8'h40;
   // copy of the control register as the host wrote it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadow <= 8'h00;
      end else if (ctrlWr) begin
         shadow <= regWdata;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sinceFall <= 4'hF;
      end else if (ctrlWr && shadow[4] && !regWdata[4]) begin
         sinceFall <= 4'h0;
      end else if (sinceFall != 4'hF) begin
         sinceFall <= sinceFall + 4'h1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busyLen <= 10'h000;
      end else begin
         busyLen <= progBusy ? busyLen + 10'h001 : 10'h000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_sel_read;
      regRead && regAddr == 8'h40 && !regWrite;
   endsequence
   sequence s_busy_read;
      s_sel_read ##0 (shadow[4] && progBusy && $past(progBusy)) ##1 progBusy;
   endsequence
   a_low_bits_zero:
      assert property (regRdata[3:0] == 4'h0) else $error("low bits set");
   a_echo_fields:
      assert property (s_sel_read |=> regRdata[6:4] == shadow[6:4])
      else $error("echo wrong");
   a_rdata_holds:
      assert property (!regRead |=> $stable(regRdata)) else $error("moved");
   a_idle_out_high:
      assert property (s_sel_read ##0 !shadow[4] |=> regRdata[7])
      else $error("out low while deselected");
   a_busy_out_low:
      assert property (s_busy_read |-> !regRdata[7]) else $error("not busy");
   a_busy_start:
      assert property ($rose(progBusy) |-> sinceFall <= 4'h4 && !shadow[4])
      else $error("busy without select fall");
   a_busy_min:
      assert property ($fell(progBusy) |-> int'(busyLen) >= PROG_CYCLES - 2)
      else $error("busy too short");
   a_busy_max:
      assert property (progBusy |-> int'(busyLen) <= PROG_CYCLES + WORDS + 8)
      else $error("busy too long");
endmodule // sep_port_properties
bind serial_data_eeprom_port sep_port_properties #(
   .WORDS(WORDS),
   .PROG_CYCLES(PROG_CYCLES)
) u_props (
   .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
   .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
   .progBusy(progBusy)
);

/* File: tb/sep_host.sv */
`timescale 1ns/1ns
module sep_host (
   input wire logic clk,
   output logic regWrite,
   output logic regRead,
   output logic [7:0] regAddr,
   output logic [7:0] regWdata,
   input wire logic [7:0] regRdata
);
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h40;
      regWdata = 8'h00;
   end
   task automatic wr(input logic [7:0] v, input logic [7:0] a = 8'h40);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr = a;
      regWdata = v;
      @(negedge clk);
      regWrite = 1'b0;
      regWdata = ~v;
      repeat (3) @(negedge clk);
   endtask
   task automatic rd(output logic [7:0] v, input logic [7:0] a = 8'h40);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRead = 1'b0;
      v = regRdata;
   endtask
   task automatic pulse(input logic b);
      wr({1'b0, b, 2'b01, 4'h0});
      wr({1'b0, b, 2'b11, 4'h0});
   endtask
   task automatic send(input logic [19:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         pulse(v[i]);
      end
   endtask
   task automatic rise(output logic b);
      logic [7:0] v;
      pulse(1'b0);
      rd(v);
      b = v[7];
   endtask
endmodule // sep_host

/* File: tb/serial_data_eeprom_port_test.sv */
`timescale 1ns/1ns
module serial_data_eeprom_port_test;
   logic clk;
   logic rst;
   logic regWrite;
   logic regRead;
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   logic progBusy;
   int failures;
   int cmp_count;

   serial_data_eeprom_port #(
      .WORDS(256),
      .PROG_CYCLES(20)
   ) u_dut (
      .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .progBusy(progBusy)
   );
   sep_host u_host (
      .clk(clk), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------
   // compare and closing
   // ------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic prog(input logic [11:0] ins, input logic [7:0] d,
                       input logic hasD, input logic en);
      logic [7:0] v;
      int n;
      u_host.wr(8'h00);
      u_host.wr(8'h10);
      u_host.send({8'h00, ins}, 12);
      if (hasD) u_host.send({12'h000, d}, 8);
      u_host.wr(8'h00);
      chkb(progBusy, en);
      u_host.wr(8'h10);
      u_host.rd(v);
      chkb(v[7], !en);
      n = 0;
      while (v[7] !== 1'b1 && n < 400) begin
         u_host.rd(v);
         n++;
      end
      chkb(v[7], 1'b1);
   endtask

   task automatic rdw(input logic [7:0] a, input int n,
                      input logic [7:0] e0, input logic [7:0] e1);
      logic [7:0] v;
      logic [7:0] w;
      logic b;
      u_host.wr(8'h00);
      u_host.wr(8'h10);
      u_host.send({8'h00, 4'hC, a}, 12);
      u_host.rise(b);
      chkb(b, 1'b0);
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 8; i++) begin
            u_host.rise(b);
            w = {w[6:0], b};
         end
         chk8(w, (k == 0) ? e0 : e1);
      end
      u_host.wr(8'h00);
      u_host.rd(v);
      chk8(v, 8'h80);
   endtask

   // about fifteen times the expected run
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      stop_test();
   end

   initial begin
      logic [7:0] v;
      failures = 0;
      cmp_count = 0;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      u_host.rd(v);
      chk8(v, 8'h80);
      chkb(progBusy, 1'b0);
      u_host.wr(8'h70, 8'h41);
      u_host.rd(v);
      chk8(v, 8'h80);
      u_host.wr(8'h70);
      u_host.rd(v, 8'h41);
      chk8(v, 8'h80);
      u_host.rd(v);
      chk8(v & 8'h7F, 8'h70);
      u_host.send(20'h00006, 3);
      $display("test register done");
      prog(12'hA05, 8'hA5, 1'b1, 1'b0);
      prog(12'h980, 8'h00, 1'b0, 1'b0);
      prog(12'h900, 8'h00, 1'b0, 1'b1);
      rdw(8'h05, 1, 8'hFF, 8'hFF);
      $display("test enable done");
      prog(12'hAFF, 8'h3C, 1'b1, 1'b1);
      prog(12'hA00, 8'hC3, 1'b1, 1'b1);
      rdw(8'hFF, 2, 8'h3C, 8'hC3);
      prog(12'hE00, 8'h00, 1'b0, 1'b1);
      rdw(8'h00, 1, 8'hFF, 8'hFF);
      $display("test word ops done");
      prog(12'h800, 8'h00, 1'b0, 1'b0);
      prog(12'hA00, 8'h11, 1'b1, 1'b0);
      rdw(8'h00, 1, 8'hFF, 8'hFF);
      prog(12'h980, 8'h00, 1'b0, 1'b0);
      prog(12'h880, 8'h5A, 1'b1, 1'b1);
      prog(12'h800, 8'h00, 1'b0, 1'b0);
      rdw(8'h07, 1, 8'h5A, 8'h5A);
      $display("test bulk ops done");
      stop_test();
   end
endmodule // serial_data_eeprom_port_test
